// ===== design/pmic_pin_pkg.sv
package pmic_pin_pkg;

  // Pin and regulator counts
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned BUCK_COUNT = 4;
  localparam int unsigned LDO_COUNT = 5;
  localparam int unsigned FUNC_W = 4;
  localparam int unsigned SLOT_W = 4;

  // Register offsets
  localparam logic [7:0] BUCK1_CONTROL_ADDR = 8'h2C;
  localparam logic [7:0] BUCK2_CONTROL_ADDR = 8'h2E;
  localparam logic [7:0] BUCK3_CONTROL_ADDR = 8'h30;
  localparam logic [7:0] BUCK4_CONTROL_ADDR = 8'h32;
  localparam logic [7:0] LINEAR_REG_ENABLE_ADDR = 8'h44;
  localparam logic [7:0] PIN_DIRECTION_ADDR = 8'h90;
  localparam logic [7:0] PIN_OUTPUT_ADDR = 8'h91;
  localparam logic [7:0] EDGE_SELECT_ADDR = 8'h92;
  localparam logic [7:0] PIN_EVENT_ADDR = 8'h93;
  localparam logic [7:0] PIN_LEVEL_ADDR = 8'h94;
  localparam logic [7:0] LED_CONTROL_ADDR = 8'h95;
  localparam logic [7:0] SLEEP_SLOT_LO_ADDR = 8'h96;
  localparam logic [7:0] SLEEP_SLOT_HI_ADDR = 8'h97;

  // Field positions
  localparam int unsigned BUCK_EN_BIT = 0;
  localparam int unsigned LED_MODE_LSB = 0;
  localparam int unsigned LED_PAT_LSB = 2;
  localparam int unsigned LED_PIN_COUNT = 2;

  // Timing
  localparam longint unsigned CLK_HZ = 100000000;
  localparam longint unsigned HOLD_WINDOW_MS = 500;
  localparam int unsigned HOLD_WINDOW_CYCLES = int'(CLK_HZ / 1000 * HOLD_WINDOW_MS);
  localparam longint unsigned SLOW_CLK_HZ = 32768;
  localparam int unsigned SLOW_HALF_CYCLES = int'(CLK_HZ / (2 * SLOW_CLK_HZ));
  localparam int unsigned BLINK_W = 15;
  localparam int unsigned BLINK_SLOW_BIT = 14;
  localparam int unsigned BLINK_FAST_BIT = 12;

  // Pin functions chosen by one-time-programmable code
  typedef enum logic [3:0] {
    FN_GPIO = 4'h0,
    FN_POWER_OFF = 4'h1,
    FN_KEY_MON = 4'h2,
    FN_POWER_GOOD = 4'h3,
    FN_ALWAYS_ON = 4'h4,
    FN_LED = 4'h5,
    FN_HOLD = 4'h6,
    FN_EXT_ON = 4'h7,
    FN_CLK_OUT = 4'h8,
    FN_HARD_RESET = 4'h9
  } pin_func_t;

  typedef enum logic [1:0] {
    SEQ_POWER_ON = 2'h0,
    SEQ_POWER_OFF = 2'h1,
    SEQ_SLEEP_ENTRY = 2'h2,
    SEQ_SLEEP_EXIT = 2'h3
  } seq_kind_t;

  localparam logic [1:0] EDGE_LEVEL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] LED_PAT_OFF = 2'h0;
  localparam logic [1:0] LED_PAT_ON = 2'h1;
  localparam logic [1:0] LED_PAT_SLOW = 2'h2;
  localparam logic [1:0] LED_PAT_FAST = 2'h3;

  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_WINDOW = 2'b01,
    HOLD_LATCHED = 2'b10
  } hold_state_t;

endpackage

// ===== design/pin_sync.sv
// Two-flop synchroniser, one chain per bit
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // First stage is read only by the second stage
  always_comb begin
    next_st = st;
    for (int i = 0; i < WIDTH; i++) begin
      next_st.first[i] = async_in[i];
      next_st.second[i] = st.first[i];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.second;

endmodule // pin_sync

// ===== design/pmic_pin_function_control.sv
//Contract
// - Normal or parts mode fixed by OTP
// - Each pin function chosen by OTP
// - Normal: sleep and key pins fixed
// - Parts: pins switch bucks, pin3 adds LDO3
// - Parts: sleep LDO1+4, key LDO2+5
// - Enable bit zero forces regulator off
// - LDO1-5 enables at 44h bits 4:0
// - Buck enables bit 0 of 2C-32h
// - OTP polarity inversion on input functions
// - GPIO direction from software register
// - GPIO output push-pull or open-drain by OTP
// - GPIO interrupts edge or level selectable
// - Key monitor pulls low while key pressed
// - Power-good changes at programmed sequence slot
// - LED power-state mode follows power (pins 0-1 only)
// - LED register mode follows pattern field while powered (pins 0-1 only)
// - Hold within 500ms keeps power on
// - Hold deassert while on requests off
// - External power-on pin requests power on
// - Hard reset pin requests off then on
// - Clock-out pin forwards 32 kHz clock
module pmic_pin_function_control
  import pmic_pin_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_WINDOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic otp_parts_mode,
  input wire logic [PIN_COUNT*FUNC_W-1:0] otp_pin_function,
  input wire logic [PIN_COUNT-1:0] otp_input_invert,
  input wire logic [PIN_COUNT-1:0] otp_open_drain,
  input wire logic [PIN_COUNT*SLOT_W-1:0] otp_power_good_slot,
  input wire logic [BUCK_COUNT-1:0] otp_buck_default,
  input wire logic [LDO_COUNT-1:0] otp_ldo_default,
  input wire logic [PIN_COUNT-1:0] multipurpose_pins_in,
  output logic [PIN_COUNT-1:0] multipurpose_pins_out,
  output logic [PIN_COUNT-1:0] multipurpose_pins_oe,
  input wire logic sleep_pin_in,
  input wire logic power_key_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic powered_on,
  input wire logic cpu_reset_active,
  input wire logic seq_step,
  input wire logic [1:0] seq_kind,
  input wire logic [SLOT_W-1:0] seq_slot,
  output logic [BUCK_COUNT-1:0] buck_enable,
  output logic [LDO_COUNT-1:0] linear_reg_enable_out,
  output logic sleep_req,
  output logic power_key_pressed,
  output logic power_off_req,
  output logic ext_power_on_req,
  output logic hard_reset_req,
  output logic power_hold_active,
  output logic always_on_regulator2_route,
  output logic [PIN_COUNT-1:0] pin_event_flags
);

  localparam int unsigned HOLD_CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned SLOW_DIV_W = $clog2(SLOW_HALF_CYCLES + 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = SLOW_DIV_W'(SLOW_HALF_CYCLES - 1);

  typedef struct packed {
    logic loaded;
    logic [BUCK_COUNT-1:0] buck_en;
    logic [LDO_COUNT-1:0] linear_reg_enable_bit;
    logic [PIN_COUNT-1:0] dir;
    logic [PIN_COUNT-1:0] gp_out;
    logic [2*PIN_COUNT-1:0] edge_sel;
    logic [PIN_COUNT-1:0] events;
    logic [5:0] led_ctl;
    logic [PIN_COUNT*SLOT_W-1:0] sleep_slot;
    logic [PIN_COUNT-1:0] pg;
    logic [PIN_COUNT-1:0] prev_level;
    logic prev_hold;
    logic prev_reset;
    hold_state_t hold;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic [SLOW_DIV_W-1:0] slow_div;
    logic slow_clk;
    logic [BLINK_W-1:0] blink;
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [BUCK_COUNT-1:0] buck_out;
    logic [LDO_COUNT-1:0] ldo_out;
    logic power_off;
    logic ext_on;
    logic hard_reset;
    logic [7:0] rdata;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic [PIN_COUNT+1:0] sync_all;
  logic [PIN_COUNT-1:0] raw_pin;
  logic [PIN_COUNT-1:0] level;
  logic sync_sleep;
  logic sync_key;
  pin_func_t fn [PIN_COUNT];

  // Pins, sleep and key pass two flops before any use
  pin_sync #(
    .WIDTH(PIN_COUNT + 2)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({power_key_in, sleep_pin_in, multipurpose_pins_in}),
    .sync_out(sync_all)
  );

  assign raw_pin = sync_all[PIN_COUNT-1:0];
  assign sync_sleep = sync_all[PIN_COUNT];
  assign sync_key = sync_all[PIN_COUNT+1];

  // Per-pin function decode and input polarity
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign fn[gi] = pin_func_t'(otp_pin_function[gi*FUNC_W +: FUNC_W]);
      assign level[gi] = raw_pin[gi] ^ otp_input_invert[gi];
    end
  endgenerate

  // Push-pull drives the value; open-drain only pulls low
  function automatic logic [1:0] drive_level(input logic v, input logic od);
    drive_level = od ? {1'b0, ~v} : {v, 1'b1};
  endfunction

  always_comb begin
    logic hold_in;
    logic off_level;
    logic ext_level;
    logic hard_reset_in_rise;
    logic hold_fall;
    logic reset_release;
    logic lit;
    logic [1:0] drv;
    logic [1:0] pat;
    hold_in = 1'b0;
    off_level = 1'b0;
    ext_level = 1'b0;
    hard_reset_in_rise = 1'b0;
    lit = 1'b0;
    drv = 2'b00;
    pat = LED_PAT_OFF;
    hold_fall = 1'b0;
    reset_release = 1'b0;
    next_st = st;

    // OTP defaults are taken once after reset release
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.buck_en = otp_buck_default;
      next_st.linear_reg_enable_bit = otp_ldo_default;
    end

    // Input functions, only meaningful in normal mode
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (!otp_parts_mode) begin
        if (fn[i] == FN_HOLD) hold_in = hold_in | level[i];
        if (fn[i] == FN_POWER_OFF) off_level = off_level | level[i];
        if (fn[i] == FN_EXT_ON) ext_level = ext_level | level[i];
        if (fn[i] == FN_HARD_RESET && level[i] && !st.prev_level[i]) begin
          hard_reset_in_rise = 1'b1;
        end
      end
    end
    next_st.prev_level = level;
    next_st.prev_hold = hold_in;
    next_st.prev_reset = cpu_reset_active;
    reset_release = st.prev_reset && !cpu_reset_active;
    hold_fall = st.prev_hold && !hold_in && powered_on;

    // Hold window after the CPU reset releases
    case (st.hold)
      HOLD_IDLE: begin
        if (reset_release && powered_on) begin
          next_st.hold = HOLD_WINDOW;
          next_st.hold_cnt = '0;
        end
      end
      HOLD_WINDOW: begin
        if (!powered_on) begin
          next_st.hold = HOLD_IDLE;
        end else if (hold_in) begin
          next_st.hold = HOLD_LATCHED;
        end else if (st.hold_cnt == HOLD_LAST) begin
          next_st.hold = HOLD_IDLE;
        end else begin
          next_st.hold_cnt = st.hold_cnt + 1'b1;
        end
      end
      HOLD_LATCHED: begin
        if (!powered_on) next_st.hold = HOLD_IDLE;
      end
      default: next_st.hold = HOLD_IDLE;
    endcase

    next_st.power_off = off_level | hold_fall;
    next_st.ext_on = ext_level;
    next_st.hard_reset = hard_reset_in_rise;

    // Slow clock divider and blink timebase
    if (st.slow_div == SLOW_LAST) begin
      next_st.slow_div = '0;
      next_st.slow_clk = ~st.slow_clk;
      if (!st.slow_clk) next_st.blink = st.blink + 1'b1;
    end else begin
      next_st.slow_div = st.slow_div + 1'b1;
    end

    // Power-good slots; a step in parts mode is ignored
    if (seq_step && !otp_parts_mode) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (fn[i] == FN_POWER_GOOD) begin
          case (seq_kind)
            SEQ_POWER_ON: begin
              if (seq_slot == otp_power_good_slot[i*SLOT_W +: SLOT_W]) next_st.pg[i] = 1'b1;
            end
            SEQ_POWER_OFF: begin
              if (seq_slot == otp_power_good_slot[i*SLOT_W +: SLOT_W]) next_st.pg[i] = 1'b0;
            end
            SEQ_SLEEP_ENTRY: begin
              if (seq_slot == st.sleep_slot[i*SLOT_W +: SLOT_W]) next_st.pg[i] = 1'b0;
            end
            SEQ_SLEEP_EXIT: begin
              if (seq_slot == st.sleep_slot[i*SLOT_W +: SLOT_W]) next_st.pg[i] = 1'b1;
            end
            default: ;
          endcase
        end
      end
    end

    // Register writes; events clear first so a new event wins
    if (reg_wr) begin
      case (reg_addr)
        BUCK1_CONTROL_ADDR: next_st.buck_en[0] = reg_wdata[BUCK_EN_BIT];
        BUCK2_CONTROL_ADDR: next_st.buck_en[1] = reg_wdata[BUCK_EN_BIT];
        BUCK3_CONTROL_ADDR: next_st.buck_en[2] = reg_wdata[BUCK_EN_BIT];
        BUCK4_CONTROL_ADDR: next_st.buck_en[3] = reg_wdata[BUCK_EN_BIT];
        LINEAR_REG_ENABLE_ADDR: next_st.linear_reg_enable_bit = reg_wdata[LDO_COUNT-1:0];
        PIN_DIRECTION_ADDR: next_st.dir = reg_wdata[PIN_COUNT-1:0];
        PIN_OUTPUT_ADDR: next_st.gp_out = reg_wdata[PIN_COUNT-1:0];
        EDGE_SELECT_ADDR: next_st.edge_sel = reg_wdata;
        PIN_EVENT_ADDR: next_st.events = st.events & ~reg_wdata[PIN_COUNT-1:0];
        LED_CONTROL_ADDR: next_st.led_ctl = reg_wdata[5:0];
        SLEEP_SLOT_LO_ADDR: next_st.sleep_slot[7:0] = reg_wdata;
        SLEEP_SLOT_HI_ADDR: next_st.sleep_slot[15:8] = reg_wdata;
        default: ;
      endcase
    end

    // GPIO input events by per-pin edge or level select
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (!otp_parts_mode && fn[i] == FN_GPIO && !st.dir[i]) begin
        case (st.edge_sel[2*i +: 2])
          EDGE_LEVEL: if (level[i]) next_st.events[i] = 1'b1;
          EDGE_RISE: if (level[i] && !st.prev_level[i]) next_st.events[i] = 1'b1;
          EDGE_FALL: if (!level[i] && st.prev_level[i]) next_st.events[i] = 1'b1;
          default: if (level[i] != st.prev_level[i]) next_st.events[i] = 1'b1;
        endcase
      end
    end

    // Regulator enables: register bit gates any pin control
    next_st.buck_out = st.buck_en;
    next_st.ldo_out = st.linear_reg_enable_bit;
    if (otp_parts_mode) begin
      for (int b = 0; b < BUCK_COUNT; b++) begin
        next_st.buck_out[b] = st.buck_en[b] & raw_pin[b];
      end
      next_st.ldo_out[2] = st.linear_reg_enable_bit[2] & raw_pin[3];
      next_st.ldo_out[0] = st.linear_reg_enable_bit[0] & sync_sleep;
      next_st.ldo_out[3] = st.linear_reg_enable_bit[3] & sync_sleep;
      next_st.ldo_out[1] = st.linear_reg_enable_bit[1] & sync_key;
      next_st.ldo_out[4] = st.linear_reg_enable_bit[4] & sync_key;
    end

    // Pin drivers; every pin is an input in parts mode
    for (int i = 0; i < PIN_COUNT; i++) begin
      drv = 2'b00;
      if (!otp_parts_mode) begin
        case (fn[i])
          FN_GPIO: begin
            if (st.dir[i]) drv = drive_level(st.gp_out[i], otp_open_drain[i]);
          end
          FN_KEY_MON: drv = {1'b0, sync_key};
          FN_POWER_GOOD: drv = drive_level(st.pg[i], otp_open_drain[i]);
          FN_LED: begin
            if (i < LED_PIN_COUNT) begin
              pat = st.led_ctl[LED_PAT_LSB + 2*i +: 2];
              if (!st.led_ctl[LED_MODE_LSB + i]) begin
                lit = powered_on;
              end else begin
                case (pat)
                  LED_PAT_ON: lit = powered_on;
                  LED_PAT_SLOW: lit = powered_on & st.blink[BLINK_SLOW_BIT];
                  LED_PAT_FAST: lit = powered_on & st.blink[BLINK_FAST_BIT];
                  default: lit = 1'b0;
                endcase
              end
              drv = {1'b0, lit};
            end
          end
          FN_CLK_OUT: drv = drive_level(st.slow_clk, otp_open_drain[i]);
          default: drv = 2'b00;
        endcase
      end
      next_st.pin_out[i] = drv[1];
      next_st.pin_oe[i] = drv[0];
    end

    // Read data registered on the read strobe
    if (reg_rd) begin
      next_st.rdata = '0;
      case (reg_addr)
        BUCK1_CONTROL_ADDR: next_st.rdata[BUCK_EN_BIT] = st.buck_en[0];
        BUCK2_CONTROL_ADDR: next_st.rdata[BUCK_EN_BIT] = st.buck_en[1];
        BUCK3_CONTROL_ADDR: next_st.rdata[BUCK_EN_BIT] = st.buck_en[2];
        BUCK4_CONTROL_ADDR: next_st.rdata[BUCK_EN_BIT] = st.buck_en[3];
        LINEAR_REG_ENABLE_ADDR: next_st.rdata[LDO_COUNT-1:0] = st.linear_reg_enable_bit;
        PIN_DIRECTION_ADDR: next_st.rdata[PIN_COUNT-1:0] = st.dir;
        PIN_OUTPUT_ADDR: next_st.rdata[PIN_COUNT-1:0] = st.gp_out;
        EDGE_SELECT_ADDR: next_st.rdata = st.edge_sel;
        PIN_EVENT_ADDR: next_st.rdata[PIN_COUNT-1:0] = st.events;
        PIN_LEVEL_ADDR: next_st.rdata[PIN_COUNT-1:0] = level;
        LED_CONTROL_ADDR: next_st.rdata[5:0] = st.led_ctl;
        SLEEP_SLOT_LO_ADDR: next_st.rdata = st.sleep_slot[7:0];
        SLEEP_SLOT_HI_ADDR: next_st.rdata = st.sleep_slot[15:8];
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from state, except sleep, key and route outputs gated by OTP
  assign multipurpose_pins_out = st.pin_out;
  assign multipurpose_pins_oe = st.pin_oe;
  assign reg_rdata = st.rdata;
  assign buck_enable = st.buck_out;
  assign linear_reg_enable_out = st.ldo_out;
  assign sleep_req = sync_sleep & ~otp_parts_mode;
  assign power_key_pressed = sync_key & ~otp_parts_mode;
  assign power_off_req = st.power_off;
  assign ext_power_on_req = st.ext_on;
  assign hard_reset_req = st.hard_reset;
  assign power_hold_active = (st.hold == HOLD_LATCHED);
  assign always_on_regulator2_route = ~otp_parts_mode & (fn[2] == FN_ALWAYS_ON);
  assign pin_event_flags = st.events;

endmodule // pmic_pin_function_control

// ===== verif/pmic_pin_function_control_props.sv
// Port-level checks, bound into every instance of the block
module pmic_pin_function_control_props
  import pmic_pin_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_WINDOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic otp_parts_mode,
  input wire logic [PIN_COUNT*FUNC_W-1:0] otp_pin_function,
  input wire logic [PIN_COUNT-1:0] otp_input_invert,
  input wire logic [PIN_COUNT-1:0] multipurpose_pins_in,
  input wire logic [PIN_COUNT-1:0] multipurpose_pins_out,
  input wire logic [PIN_COUNT-1:0] multipurpose_pins_oe,
  input wire logic sleep_pin_in,
  input wire logic power_key_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [BUCK_COUNT-1:0] buck_enable,
  input wire logic [LDO_COUNT-1:0] linear_reg_enable_out,
  input wire logic sleep_req,
  input wire logic power_key_pressed,
  input wire logic ext_power_on_req,
  input wire logic hard_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Parts mode: a regulator may only be on if its pin was high three edges back
  a_parts_buck_pin: assert property (otp_parts_mode && buck_enable[1] |-> $past(multipurpose_pins_in[1], 3))
    else $error("buck2 on without its pin");
  a_parts_ldo3_pin: assert property (otp_parts_mode && linear_reg_enable_out[2] |-> $past(multipurpose_pins_in[3], 3))
    else $error("ldo3 on without pin3");
  a_parts_no_drive: assert property (otp_parts_mode |-> multipurpose_pins_oe == 4'h0)
    else $error("pin driven in parts mode");
  a_parts_sleep_ldo: assert property (otp_parts_mode && (linear_reg_enable_out[0] || linear_reg_enable_out[3]) |-> $past(sleep_pin_in, 3))
    else $error("ldo1 or ldo4 on without sleep pin");
  a_parts_key_ldo: assert property (otp_parts_mode && (linear_reg_enable_out[1] || linear_reg_enable_out[4]) |-> $past(power_key_in, 3))
    else $error("ldo2 or ldo5 on without key pin");
  a_buck_write_off: assert property (reg_wr && reg_addr == BUCK1_CONTROL_ADDR && !reg_wdata[0] |-> ##[1:3] !buck_enable[0])
    else $error("buck1 stays on after zero write");
  a_ldo_read_back: assert property (reg_wr && reg_addr == LINEAR_REG_ENABLE_ADDR ##1 reg_rd && !reg_wr && reg_addr == LINEAR_REG_ENABLE_ADDR |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F))
    else $error("ldo enable read back differs");
  a_sleep_key_fixed: assert property (otp_parts_mode |-> !sleep_req && !power_key_pressed)
    else $error("sleep or key request in parts mode");
  a_sleep_follow: assert property (!otp_parts_mode && sleep_pin_in [*3] |-> sleep_req)
    else $error("sleep request missing");
  a_key_mon_low: assert property (!otp_parts_mode && otp_pin_function[3:0] == FN_KEY_MON && power_key_in [*3] |=> multipurpose_pins_oe[0] && !multipurpose_pins_out[0])
    else $error("key monitor not low");
  a_ext_on_req: assert property (!otp_parts_mode && otp_pin_function[15:12] == FN_EXT_ON && (multipurpose_pins_in[3] ^ otp_input_invert[3]) [*3] |=> ext_power_on_req)
    else $error("external power-on request missing");
  a_hard_pulse: assert property (hard_reset_req |-> !otp_parts_mode ##1 !hard_reset_req)
    else $error("hard reset request not one cycle");
endmodule // pmic_pin_function_control_props

bind pmic_pin_function_control pmic_pin_function_control_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// ===== verif/board_model.sv
// Board and power-state stand-in facing the pins
module board_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] pins_oe,
  input wire logic [3:0] pins_out,
  input wire logic [3:0] drv_en,
  input wire logic [3:0] drv_val,
  output logic [3:0] pins_level,
  input wire logic ext_on,
  input wire logic off_req,
  input wire logic hard_req,
  output logic powered_on,
  output logic cpu_reset_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rst_cnt;

  // Pull-up wire: any low driver wins, so open drain only pulls low
  assign pins_level = ~((pins_oe & ~pins_out) | (drv_en & ~drv_val));
  assign cpu_reset_active = rst_cnt != 3'h0;

  // Power on by request, off on off or hard reset; cpu reset after power up
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      powered_on <= 1'h0;
      rst_cnt <= 3'h0;
    end else begin
      if (ext_on) powered_on <= 1'h1;
      else if (off_req || hard_req) powered_on <= 1'h0;
      if (ext_on && !powered_on) rst_cnt <= 3'h4;
      else if (rst_cnt != 3'h0) rst_cnt <= rst_cnt - 3'h1;
    end
  end
endmodule // board_model

// ===== verif/pmic_pin_function_control_tb_top.sv
module pmic_pin_function_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmic_pin_pkg::*;
  logic core_clk = 1'h0, reset_n = 1'h0, parts = 1'h0, sleep = 1'h0, key = 1'h0;
  logic wr = 1'h0, rd = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q, d;
  logic [3:0] inv, od, bdef, pins, oe, pout, den = 4'hA, dval, bk, ev;
  logic [4:0] ldef, ldo;
  logic slp_r, key_r, off_r, ext_r, hard_r, hold_a, pwr, cpu_rst;
  logic [15:0] fn;
  logic [7:0] baddr [4];
  int seed = 62;
  int error_cnt = 0;
  int n_tests = 0;

  pmic_pin_function_control #(.HOLD_CYCLES(50)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .otp_parts_mode(parts),
    .otp_pin_function(fn), .otp_input_invert(inv), .otp_open_drain(od),
    .otp_power_good_slot(16'h0000), .otp_buck_default(bdef), .otp_ldo_default(ldef),
    .multipurpose_pins_in(pins), .multipurpose_pins_out(pout), .multipurpose_pins_oe(oe),
    .sleep_pin_in(sleep), .power_key_in(key), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .powered_on(pwr), .cpu_reset_active(cpu_rst),
    .seq_step(1'h0), .seq_kind(2'h0), .seq_slot(4'h0), .buck_enable(bk),
    .linear_reg_enable_out(ldo), .sleep_req(slp_r), .power_key_pressed(key_r),
    .power_off_req(off_r), .ext_power_on_req(ext_r), .hard_reset_req(hard_r),
    .power_hold_active(hold_a), .always_on_regulator2_route(), .pin_event_flags(ev));

  board_model u_board (
    .core_clk(core_clk), .reset_n(reset_n), .pins_oe(oe), .pins_out(pout), .drv_en(den),
    .drv_val(dval), .pins_level(pins), .ext_on(ext_r), .off_req(off_r), .hard_req(hard_r),
    .powered_on(pwr), .cpu_reset_active(cpu_rst));

  always #5 core_clk = ~core_clk;

  // Expected LDO enables in parts mode with all bits set
  function automatic logic [4:0] parts_ldo(logic [3:0] p, logic s, logic k);
    return {k, s, p[3], k, s};
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle edge first, so a write never re-raises wr in the step that lowered it
  task automatic wreg(logic [7:0] a, logic [7:0] v);
    tick(1);
    addr = a;
    wdata = v;
    wr = 1'h1;
    tick(1);
    wr = 1'h0;
  endtask

  // Data is valid just after the edge that samples the read strobe
  task automatic rreg(logic [7:0] a, output logic [7:0] v);
    addr = a;
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    v = rdata;
    tick(1);
  endtask

  // OTP inputs are static, so mode changes only across a reset
  task automatic do_reset(logic m);
    reset_n = 1'h0;
    parts = m;
    tick(2);
    reset_n = 1'h1;
    tick(2);
  endtask

  task automatic give_verdict();
    $display("counts: comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  initial begin
    #500us;
    error_cnt++;
    give_verdict();
  end

  initial begin
    baddr = '{BUCK1_CONTROL_ADDR, BUCK2_CONTROL_ADDR, BUCK3_CONTROL_ADDR, BUCK4_CONTROL_ADDR};
    fn = {FN_EXT_ON, FN_GPIO, FN_HARD_RESET, FN_KEY_MON};
    inv = 4'($random(seed));
    od = 4'($random(seed));
    bdef = 4'($random(seed));
    ldef = 5'($random(seed));
    dval = inv;
    do_reset(1'h0);
    rreg(LINEAR_REG_ENABLE_ADDR, q);
    chk(q, {3'h0, ldef});
    for (int i = 0; i < 4; i++) begin
      rreg(baddr[i], q);
      chk(q[0], bdef[i]);
    end
    rreg(8'h45, q);
    chk(q, 8'h00);
    $display("test reset values done");
    repeat (8) begin
      d = 8'($random(seed));
      wreg(LINEAR_REG_ENABLE_ADDR, d);
      rreg(LINEAR_REG_ENABLE_ADDR, q);
      chk(q, d & 8'h1F);
      addr = baddr[$unsigned($random(seed)) % 4];
      wreg(addr, d);
      rreg(addr, q);
      chk(q[0], d[0]);
    end
    $display("test register access done");
    key = 1'h1;
    sleep = 1'h1;
    tick(4);
    chk({oe[0], pout[0], key_r, slp_r}, 8'h0B);
    key = 1'h0;
    tick(4);
    chk({oe[0], key_r}, 8'h00);
    dval[1] = ~inv[1];
    tick(3);
    chk(hard_r, 1'h1);
    tick(1);
    chk(hard_r, 1'h0);
    dval[1] = inv[1];
    dval[3] = ~inv[3];
    tick(4);
    chk(ext_r, 1'h1);
    dval[3] = inv[3];
    $display("test pin functions done");
    wreg(PIN_OUTPUT_ADDR, 8'h04);
    wreg(PIN_DIRECTION_ADDR, 8'h04);
    tick(2);
    chk({oe[2], pout[2] | od[2]}, {~od[2], 1'h1});
    wreg(PIN_OUTPUT_ADDR, 8'h00);
    tick(2);
    chk({oe[2], pout[2]}, 8'h02);
    wreg(PIN_DIRECTION_ADDR, 8'h00);
    den[2] = 1'h1;
    dval[2] = inv[2];
    wreg(EDGE_SELECT_ADDR, {2'h0, EDGE_RISE, 4'h0});
    tick(3);
    wreg(PIN_EVENT_ADDR, 8'h0F);
    tick(3);
    chk(ev[2], 1'h0);
    dval[2] = ~inv[2];
    tick(4);
    chk(ev[2], 1'h1);
    rreg(PIN_LEVEL_ADDR, q);
    chk(q[2], 1'h1);
    wreg(PIN_EVENT_ADDR, 8'h04);
    tick(1);
    chk(ev[2], 1'h0);
    wreg(EDGE_SELECT_ADDR, {2'h0, EDGE_LEVEL, 4'h0});
    tick(3);
    chk(ev[2], 1'h1);
    $display("test gpio done");
    den = 4'hF;
    do_reset(1'h1);
    for (int i = 0; i < 4; i++) wreg(baddr[i], 8'h01);
    wreg(LINEAR_REG_ENABLE_ADDR, 8'h1F);
    repeat (12) begin
      dval = 4'($random(seed));
      sleep = 1'($random(seed));
      key = 1'($random(seed));
      tick(4);
      chk(bk, dval);
      chk(ldo, parts_ldo(dval, sleep, key));
    end
    dval = 4'hF;
    wreg(BUCK1_CONTROL_ADDR, 8'h00);
    wreg(LINEAR_REG_ENABLE_ADDR, 8'h00);
    tick(3);
    chk({bk, 4'h0}, 8'hE0);
    chk(ldo, 8'h00);
    $display("test parts mode done");
    // Hold, LED and clock-out pins; OTP changes only across a reset
    fn = {FN_EXT_ON, FN_CLK_OUT, FN_HOLD, FN_LED};
    den = 4'hA;
    dval = inv;
    do_reset(1'h0);
    chk(oe[0], 1'h0);
    dval[3] = ~inv[3];
    tick(7);
    chk({oe[0], pout[0], pwr}, 8'h05);
    dval[1] = ~inv[1];
    dval[3] = inv[3];
    tick(8);
    chk(hold_a, 1'h1);
    dval[1] = inv[1];
    tick(7);
    chk({hold_a, pwr, oe[0]}, 8'h00);
    q = {6'h00, oe[2], pout[2]};
    tick(SLOW_HALF_CYCLES);
    chk({oe[2], pout[2]} ^ q[1:0], {od[2], ~od[2]});
    $display("test hold led and clock done");
    give_verdict();
  end
endmodule // pmic_pin_function_control_tb_top
